// ===== host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   output logic serial_clock,
   output logic serial_data,
   output logic serial_latch
);
   initial {serial_clock, serial_data, serial_latch} = 3'b001;
   // write only: nothing comes back, so a word cannot be confirmed
   // the feedback divider lives in another word; a host wanting the
   // quarter shift sets divide sixteen there as well
   task automatic send(input logic [31:0] w);
      serial_latch = 0;
      for (int i = 31; i >= 0; i--) begin
         serial_data = w[i];
         #400 serial_clock = 1;
         #400 serial_clock = 0;
      end
      serial_data = ~serial_data;
      #400 serial_latch = 1;
      #400;
   endtask
endmodule
`default_nettype wire

// ===== osc_word_chk.sv
`timescale 1ns/1ps
`default_nettype none
module osc_word_chk (
   input wire logic mclk,
   input wire logic reset,
   input wire logic power_down_control,
   input wire logic serial_latch,
   input wire logic pump_current_reference,
   input wire logic oscillator_status_pin,
   input wire logic quarter_shift_divide_four,
   input wire logic quarter_shift_divide_eight,
   input wire logic output_divide_sixteen_allowed,
   input wire logic outputs_switch_in_pairs,
   input wire logic [4:0] pair_signaling_select,
   input wire logic [19:0] output_mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   wire f4 = quarter_shift_divide_four, f8 = quarter_shift_divide_eight;
   wire d16 = output_divide_sixteen_allowed, pd = power_down_control;
   // eight quiet cycles clear the sync stages, so a held word must not move
   wire idle = !serial_latch && !pd;
   a_shift_single: assert property (!(f4 && f8)) else $error("two shifts");
   a_div16_gone: assert property (f4 || f8 |-> !d16) else $error("div16 kept");
   a_pair_switch: assert property (outputs_switch_in_pairs == (f4 || f8))
      else $error("pair switching");
   a_cref_pin: assert property (pump_current_reference |-> !oscillator_status_pin)
      else $error("status pin");
   a_pd_signal: assert property (pd [*8] |-> pair_signaling_select == 5'h1f)
      else $error("signaling default");
   a_pd_mode: assert property (pd [*8] |-> output_mode == 20'h0_0000 && d16)
      else $error("mode default");
   a_mode_hold: assert property (idle [*8] |-> $stable(output_mode)) else $error("mode moved");
   a_word_hold: assert property (idle [*8] |-> $stable({f4, f8, pair_signaling_select}))
      else $error("word moved");
   cover property (f4);
   cover property (f8);
   cover property (pd [*8]);
endmodule
bind output_status_config_word osc_word_chk chk (
   .mclk(mclk),
   .reset(reset),
   .power_down_control(power_down_control),
   .serial_latch(serial_latch),
   .pump_current_reference(pump_current_reference),
   .oscillator_status_pin(oscillator_status_pin),
   .quarter_shift_divide_four(quarter_shift_divide_four),
   .quarter_shift_divide_eight(quarter_shift_divide_eight),
   .output_divide_sixteen_allowed(output_divide_sixteen_allowed),
   .outputs_switch_in_pairs(outputs_switch_in_pairs),
   .pair_signaling_select(pair_signaling_select),
   .output_mode(output_mode)
);
`default_nettype wire

// ===== output_status_config_defs.vh
`ifndef OUTPUT_STATUS_CONFIG_DEFS_VH
`define OUTPUT_STATUS_CONFIG_DEFS_VH
// word select code in bits 1:0
`define WORD_SELECT_CODE 2'b01
`define WORD_SELECT_LSB 0
`define WORD_SELECT_MSB 1
// field positions
`define SIGNALING_LSB 2
`define MODE_LSB 7
`define MODE_MSB 26
`define REFSTAT_FUNC_BIT 27
`define OSCSTAT_CREF_BIT 28
`define LOCK_SOURCE_BIT 29
`define SHIFT_DIV4_BIT 30
`define SHIFT_DIV8_BIT 31
// reset values of the word
`define SIGNALING_RESET 5'h1f
`define MODE_RESET 20'h0_0000
`define CONFIG_WORD_RESET 32'h0000_007d
`define WORD_WIDTH 32
// idle levels of the synchronised pins, clock at bit 0; only the latch idles high
`define PIN_IDLE_LEVELS 9'h004
`endif

// ===== output_status_config_word.v
// Functional notes
// RQ1: pair bit: one differential, zero single-ended
// RQ2: ten two-bit modes, bits 7 to 26
// RQ3: bit 27 low: pin shows reference status
// RQ4: bit 27 high: pin shows selected reference
// RQ5: bit 28 picks oscillator status or current reference
// RQ6: bit 29 picks digital or analog lock
// RQ7: bit 30 enables quarter shift, divide four
// RQ8: bit 31 enables quarter shift, divide eight
// RQ9: host must also pick feedback divide sixteen
// RQ10: shift active removes output divide sixteen
// RQ11: shift active switches outputs in pairs
// RQ12: host sets at most one shift bit
// RQ13: both shift bits set means no shift
// RQ14: write only, no read-back or acknowledge
// RQ15: defaults on reset and power-down
// RQ16: accept word only when select bits equal 01
`timescale 1ns/1ps
`default_nettype none
`include "output_status_config_defs.vh"
module output_status_config_word #(
   parameter WORD_BITS = `WORD_WIDTH
) (
   input wire mclk,
   input wire reset,
   input wire power_down_control,
   input wire serial_clock,
   input wire serial_data,
   input wire serial_latch,
   input wire ref_clock_status,
   input wire primary_selected,
   input wire oscillator_status,
   input wire digital_lock,
   input wire analog_lock,
   output reg [4:0] pair_signaling_select,
   output reg [19:0] output_mode,
   output reg refstat_pin,
   output reg oscillator_status_pin,
   output reg pump_current_reference,
   output reg lock_pin,
   output reg lock_detector_source,
   output reg quarter_shift_divide_four,
   output reg quarter_shift_divide_eight,
   output reg output_divide_sixteen_allowed,
   output reg outputs_switch_in_pairs
);
   // ****************************************
   // input synchronisers
   // ****************************************
   // every pin is asynchronous to mclk and passes two flops before use
   localparam PIN_COUNT = 9;
   localparam PIN_CLOCK = 0;
   localparam PIN_DATA = 1;
   localparam PIN_LATCH = 2;
   localparam PIN_POWER_DOWN = 3;
   localparam PIN_REF_STATUS = 4;
   localparam PIN_PRIMARY = 5;
   localparam PIN_OSC_STATUS = 6;
   localparam PIN_DIGITAL_LOCK = 7;
   localparam PIN_ANALOG_LOCK = 8;
   // stages start at each pin's idle level, so reset release shows no edge
   localparam [PIN_COUNT-1:0] PIN_IDLE = `PIN_IDLE_LEVELS;
   wire [PIN_COUNT-1:0] pin_raw;
   wire [PIN_COUNT-1:0] pin_sync;
   assign pin_raw[PIN_CLOCK] = serial_clock;
   assign pin_raw[PIN_DATA] = serial_data;
   assign pin_raw[PIN_LATCH] = serial_latch;
   assign pin_raw[PIN_POWER_DOWN] = power_down_control;
   assign pin_raw[PIN_REF_STATUS] = ref_clock_status;
   assign pin_raw[PIN_PRIMARY] = primary_selected;
   assign pin_raw[PIN_OSC_STATUS] = oscillator_status;
   assign pin_raw[PIN_DIGITAL_LOCK] = digital_lock;
   assign pin_raw[PIN_ANALOG_LOCK] = analog_lock;
   genvar pin;
   generate
      for (pin = 0; pin < PIN_COUNT; pin = pin + 1) begin : g_pin_sync
         reg stage_a;
         reg stage_b;
         // only the second stage is read; the first may still be settling
         always @(posedge mclk or posedge reset) begin
            if (reset) begin
               stage_a <= PIN_IDLE[pin];
               stage_b <= PIN_IDLE[pin];
            end else begin
               stage_a <= pin_raw[pin];
               stage_b <= stage_a;
            end
         end
         assign pin_sync[pin] = stage_b;
      end
   endgenerate
   wire s_clk = pin_sync[PIN_CLOCK];
   wire s_data = pin_sync[PIN_DATA];
   wire s_latch = pin_sync[PIN_LATCH];
   wire s_pd = pin_sync[PIN_POWER_DOWN];
   wire s_ref_status = pin_sync[PIN_REF_STATUS];
   wire s_primary = pin_sync[PIN_PRIMARY];
   wire s_osc_status = pin_sync[PIN_OSC_STATUS];
   wire s_digital_lock = pin_sync[PIN_DIGITAL_LOCK];
   wire s_analog_lock = pin_sync[PIN_ANALOG_LOCK];
   // ****************************************
   // edge detection
   // ****************************************
   // previous values also start idle: a latch that idles high must not
   // look like a fresh commit just after reset
   reg clk_prev;
   reg latch_prev;
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         clk_prev <= PIN_IDLE[PIN_CLOCK];
         latch_prev <= PIN_IDLE[PIN_LATCH];
      end else begin
         clk_prev <= s_clk;
         latch_prev <= s_latch;
      end
   end
   wire clk_rise = s_clk & ~clk_prev;
   wire latch_rise = s_latch & ~latch_prev;
   // ****************************************
   // shift register and stored word
   // ****************************************
   // msb first; the last bit shifted in is bit 0
   // no read-back path exists at all (see RQ14)
   reg [WORD_BITS-1:0] shifter;
   reg [WORD_BITS-1:0] word;
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         shifter <= {WORD_BITS{1'b0}};
         word <= `CONFIG_WORD_RESET;
      end else begin
         if (clk_rise & ~s_latch)
            shifter <= {shifter[WORD_BITS-2:0], s_data};
         if (s_pd)
            word <= `CONFIG_WORD_RESET; // see RQ15
         else if (latch_rise &&
                  shifter[`WORD_SELECT_MSB:`WORD_SELECT_LSB] == `WORD_SELECT_CODE)
            word <= shifter; // see RQ16
      end
   end
   // ****************************************
   // decode
   // ****************************************
   wire sh4 = word[`SHIFT_DIV4_BIT];
   wire sh8 = word[`SHIFT_DIV8_BIT];
   // both set cancels both shifts, but divide sixteen stays removed, unlike the off setting (see RQ13)
   wire eff4 = sh4 & ~sh8; // see RQ7
   wire eff8 = sh8 & ~sh4; // see RQ8
   wire shift_on = eff4 | eff8;
   // divide sixteen goes away on either bit, even when the two cancel
   wire shift_requested = sh4 | sh8;
   wire refsel = word[`REFSTAT_FUNC_BIT];
   wire cref = word[`OSCSTAT_CREF_BIT];
   wire lsrc = word[`LOCK_SOURCE_BIT];
   // ****************************************
   // per pair fields
   // ****************************************
   // each pair owns a signaling bit and two mode fields, side a below side b
   localparam PAIR_COUNT = 5;
   localparam MODE_BITS = 2;
   wire [PAIR_COUNT-1:0] next_signaling;
   wire [2*MODE_BITS*PAIR_COUNT-1:0] next_mode;
   genvar pair;
   generate
      for (pair = 0; pair < PAIR_COUNT; pair = pair + 1) begin : g_pair
         localparam MODE_A = `MODE_LSB + 2 * MODE_BITS * pair;
         localparam MODE_B = MODE_A + MODE_BITS;
         localparam OUT_A = 2 * MODE_BITS * pair;
         localparam OUT_B = OUT_A + MODE_BITS;
         // one bit sets the standard of both outputs of the pair
         assign next_signaling[pair] = word[`SIGNALING_LSB + pair]; // see RQ1
         assign next_mode[OUT_A+MODE_BITS-1:OUT_A] = word[MODE_A+MODE_BITS-1:MODE_A]; // see RQ2
         assign next_mode[OUT_B+MODE_BITS-1:OUT_B] = word[MODE_B+MODE_BITS-1:MODE_B]; // see RQ2
      end
   endgenerate
   // ****************************************
   // status pin and lock routing
   // ****************************************
   reg next_refstat;
   reg next_osc_pin;
   reg next_lock;
   always @* begin
      if (refsel) begin
         next_refstat = s_primary; // see RQ4
      end else begin
         next_refstat = s_ref_status; // see RQ3
      end
      // the shared pin gives up the status signal while it sets pump current
      if (cref) begin
         next_osc_pin = 1'b0; // see RQ5
      end else begin
         next_osc_pin = s_osc_status; // see RQ5
      end
      if (lsrc) begin
         next_lock = s_analog_lock; // see RQ6
      end else begin
         next_lock = s_digital_lock; // see RQ6
      end
   end
   // ****************************************
   // registered outputs
   // ****************************************
   // every output leaves a flop, so the pins never show decode glitches;
   // the cost is one extra mclk between a commit and the pins
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         pair_signaling_select <= `SIGNALING_RESET;
         output_mode <= `MODE_RESET;
         refstat_pin <= 1'b0;
         oscillator_status_pin <= 1'b0;
         pump_current_reference <= 1'b0;
         lock_pin <= 1'b0;
         lock_detector_source <= 1'b0;
         quarter_shift_divide_four <= 1'b0;
         quarter_shift_divide_eight <= 1'b0;
         output_divide_sixteen_allowed <= 1'b1;
         outputs_switch_in_pairs <= 1'b0;
      end else begin
         pair_signaling_select <= next_signaling; // see RQ1
         output_mode <= next_mode; // see RQ2
         refstat_pin <= next_refstat;
         oscillator_status_pin <= next_osc_pin;
         pump_current_reference <= cref; // see RQ5
         lock_pin <= next_lock;
         lock_detector_source <= lsrc; // see RQ6
         quarter_shift_divide_four <= eff4; // see RQ7
         quarter_shift_divide_eight <= eff8; // see RQ8
         output_divide_sixteen_allowed <= ~shift_requested; // see RQ10
         outputs_switch_in_pairs <= shift_on; // see RQ11
      end
   end
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk = 0, reset = 1, power_down_control = 0;
   logic [4:0] s = 0;
   logic [33:0] q[$];
   wire [33:0] g;
   wire sc, sd, sl;
   int err_total = 0, checks = 0;
   event look;
   initial forever #50 mclk = ~mclk;
   host_model host (.serial_clock(sc), .serial_data(sd), .serial_latch(sl));
   output_status_config_word dut (.mclk(mclk), .reset(reset), .power_down_control(power_down_control),
      .serial_clock(sc), .serial_data(sd), .serial_latch(sl), .ref_clock_status(s[0]),
      .primary_selected(s[1]), .oscillator_status(s[2]), .digital_lock(s[3]), .analog_lock(s[4]),
      .pair_signaling_select(g[33:29]), .output_mode(g[28:9]), .refstat_pin(g[8]),
      .oscillator_status_pin(g[7]), .pump_current_reference(g[6]), .lock_pin(g[5]),
      .lock_detector_source(g[4]), .quarter_shift_divide_four(g[3]),
      .quarter_shift_divide_eight(g[2]), .output_divide_sixteen_allowed(g[1]),
      .outputs_switch_in_pairs(g[0]));
   task automatic note(input logic [31:0] w);
      q.push_back({w[6:2], w[26:7], w[27] ? s[1] : s[0], ~w[28] & s[2], w[28], w[29] ? s[4] : s[3],
         w[29], w[30] & ~w[31], w[31] & ~w[30], ~(w[30] | w[31]), w[30] ^ w[31]});
      // read at the falling edge, clear of the edge that moves the outputs
      repeat (12) @(negedge mclk);
      -> look;
      // let the watcher take this note before the caller moves on or ends
      @(posedge mclk);
   endtask
   task automatic compare;
      checks++;
      if (g !== q[0]) begin
         err_total++;
         $display("wrong value at %0t: %h vs %h", $time, g, q[0]);
      end
      void'(q.pop_front());
   endtask
   always @(look) compare;
   task automatic stop_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #2_000_000 err_total++;
      stop_test;
   end
   initial begin
      logic [31:0] w, k;
      void'($urandom(85902));
      repeat (4) @(posedge mclk);
      @(negedge mclk) reset = 0;
      k = 32'h0000_007d;
      note(k);
      $display("defaults done");
      for (int i = 0; i < 20; i++) begin
         w = $urandom;
         // i of 12 to 15 sets both shift bits, past what a host may do
         w[31:28] = i[3:0];
         // the last four words carry a foreign select code and must leave k standing
         w[1:0] = i < 16 ? 2'b01 : (i[1:0] == 2'b01 ? 2'b10 : i[1:0]);
         k = i < 16 ? w : k;
         @(negedge mclk) s = 5'($urandom);
         host.send(w);
         note(k);
      end
      $display("word tests done");
      @(negedge mclk) power_down_control = 1;
      note(32'h0000_007d);
      $display("power down done");
      stop_test;
   end
endmodule
`default_nettype wire
